// ===== mob_ais_tx_sequencer.sv
// transmit sequencer: slot timing, burst plan, frame serialiser, keying guard, axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - keyed longer than 2 s under fault: hardware cuts the transmitter off.
// - transmit on AIS1 and AIS2 with modified self-organised slots, UTC synchronised.
// - only position report type 1 and safety text type 14 are sent.
// - active mode: nav status 14, text MOB ACTIVE.
// - test mode: nav status 15, text MOB TEST.
// - slot boundaries follow the receiver's UTC pulse.
// - after first fix, position refreshed at least every minute.
// - active start once fix, SOG, COG, UTC lock present, else by 60 s.
// - optional unsynchronised default message between 10 s and 30 s.
// - synchronised correct-position transmissions within 5 minutes of activation.
// - once started, transmission continues whatever the receiver does.
// - without UTC lock the slot timebase free-runs.
// - lost fix: keep sending last valid position.
// - test mode: exactly one burst, only once fix, SOG, COG, time present.
// - test burst waits for UTC lock even with stale UTC parameters.
// - no UTC lock five minutes into test: leave test mode silently.
// - slot frame repeats every two seconds; transmissions start on slot edges.
// - cold start may use only valid stored leap-second data.
// - transmissions in a burst 75 slots apart, alternating channels.
// - test burst: 8 messages, type 14 first and last, type 1 between.
// - no fix: longitude 181, latitude 91, COG not available.
module mob_ais_tx_sequencer #(
   parameter int SEC_CYC    = mob_pkg::SEC_S * mob_pkg::CLK_HZ,
   parameter int SLOT_CYC   = (mob_pkg::SLOT_FRAME_S * mob_pkg::CLK_HZ) / mob_pkg::SLOTS_FRAME,
   parameter int SETTLE_CYC = (mob_pkg::SETTLE_US * (mob_pkg::CLK_HZ / 1000) + 999) / 1000,
   parameter int RAMP_CYC   = (mob_pkg::RAMP_US * (mob_pkg::CLK_HZ / 1000)) / 1000,
   parameter int KEY_MAX_CYC = (mob_pkg::KEY_MAX_US * (mob_pkg::CLK_HZ / 1000)) / 1000,
   parameter int STUCK_CYC  = mob_pkg::STUCK_S * mob_pkg::CLK_HZ
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire mob_pkg::gnss_s gnss,
   output mob_pkg::radio_s    radio,
   output logic               pos_refresh,
   output logic               leap_aid
);
   // ****************************************
   // registers seen by software
   // ****************************************
   logic [3:0]  ctrl;
   logic [29:0] mmsi;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic [31:0] status;

   mob_pkg::seq_e seq;
   mob_pkg::ser_e ser;
   logic        shut;
   logic        abandoned;
   logic        started;
   logic        have_fix;
   logic [7:0]  tx_count;
   logic [26:0] lat_q;
   logic [27:0] lon_q;
   logic [9:0]  sog_q;
   logic [11:0] cog_q;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == mob_pkg::REG_CTRL) || (a == mob_pkg::REG_STATUS) || (a == mob_pkg::REG_LAT)
               || (a == mob_pkg::REG_LON) || (a == mob_pkg::REG_MMSI);
   endfunction : mapped

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign leap_aid      = ctrl[mob_pkg::CTRL_LEAP];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end
      else if (s_axi_bvalid)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= mob_pkg::RESP_OK;
         ctrl         <= 4'h0;
         mmsi         <= mob_pkg::MMSI_RESET;
      end
      else if (s_axi_bvalid)
         s_axi_bvalid <= !s_axi_bready;
      else if (aw_held && w_held)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(aw_addr) ? mob_pkg::RESP_OK : mob_pkg::RESP_ERR;
         if (aw_addr == mob_pkg::REG_CTRL && w_strb[0])
            ctrl <= w_data[3:0];
         if (aw_addr == mob_pkg::REG_MMSI)
         begin
            for (int b = 0; b < 4; b++)
               if (w_strb[b])
                  mmsi[b*8 +: 6] <= w_data[b*8 +: 6];
            if (w_strb[0])
               mmsi[7:6] <= w_data[7:6];
            if (w_strb[1])
               mmsi[15:14] <= w_data[15:14];
            if (w_strb[2])
               mmsi[23:22] <= w_data[23:22];
         end
      end
   end

   assign status = {16'h0000, tx_count, have_fix, started, abandoned, shut, 4'(seq)};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= mob_pkg::RESP_OK;
      end
      else if (s_axi_rvalid)
         s_axi_rvalid <= !s_axi_rready;
      else if (s_axi_arvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= mapped(s_axi_araddr) ? mob_pkg::RESP_OK : mob_pkg::RESP_ERR;
         case (s_axi_araddr)
            mob_pkg::REG_CTRL:   s_axi_rdata <= {28'h0000000, ctrl};
            mob_pkg::REG_STATUS: s_axi_rdata <= status;
            mob_pkg::REG_LAT:    s_axi_rdata <= {5'h00, lat_q};
            mob_pkg::REG_LON:    s_axi_rdata <= {4'h0, lon_q};
            mob_pkg::REG_MMSI:   s_axi_rdata <= {2'h0, mmsi};
            default:             s_axi_rdata <= 32'h00000000;
         endcase
      end
   end

   // ****************************************
   // timebase: seconds, utc second and slots
   // ****************************************
   logic [23:0] sec_cnt;
   logic [8:0]  secs;
   logic [5:0]  utc_sec;
   logic [5:0]  refresh_sec;
   logic        pps_q;
   logic        pps_rise;
   logic [19:0] slot_cyc;
   logic [6:0]  slot_no;
   logic        slot_tick;
   logic        sec_tick;

   assign sec_tick  = (sec_cnt == 24'(SEC_CYC - 1));
   assign pps_rise  = gnss.pps && !pps_q;
   assign slot_tick = (slot_cyc == 20'(SLOT_CYC - 1));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sec_cnt <= 24'h000000;
         pps_q   <= 1'b0;
         utc_sec <= 6'h00;
      end
      else
      begin
         pps_q   <= gnss.pps;
         sec_cnt <= sec_tick ? 24'h000000 : sec_cnt + 24'h000001;
         if (pps_rise && gnss.utc_lock)
            utc_sec <= (utc_sec == 6'h3b) ? 6'h00 : utc_sec + 6'h01;
      end
   end

   // locked: every even utc second restarts the 75-slot frame; unlocked: free-run
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         slot_cyc <= 20'h00000;
         slot_no  <= 7'h00;
      end
      else if (pps_rise && gnss.utc_lock && utc_sec[0])
      begin
         slot_cyc <= 20'h00000;
         slot_no  <= 7'h00;
      end
      else if (slot_tick)
      begin
         slot_cyc <= 20'h00000;
         slot_no  <= (slot_no == 7'(mob_pkg::SLOTS_FRAME - 1)) ? 7'h00 : slot_no + 7'h01;
      end
      else
         slot_cyc <= slot_cyc + 20'h00001;
   end

   // ****************************************
   // position store
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         have_fix <= 1'b0;
         lat_q    <= mob_pkg::LAT_NA;
         lon_q    <= mob_pkg::LON_NA;
         sog_q    <= mob_pkg::SOG_NA;
         cog_q    <= mob_pkg::COG_NA;
      end
      else if (gnss.fix && gnss.sog_cog)
      begin
         have_fix <= 1'b1;
         lat_q    <= gnss.lat;
         lon_q    <= gnss.lon;
         sog_q    <= gnss.sog;
         cog_q    <= gnss.cog;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         refresh_sec <= 6'h00;
         pos_refresh <= 1'b0;
      end
      else
      begin
         pos_refresh <= 1'b0;
         if (have_fix && sec_tick)
         begin
            refresh_sec <= (refresh_sec == 6'(mob_pkg::REFRESH_S - 1)) ? 6'h00 : refresh_sec + 6'h01;
            pos_refresh <= (refresh_sec == 6'(mob_pkg::REFRESH_S - 1));
         end
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   logic        ready_all;
   logic        act;
   logic        early_done;
   logic [2:0]  burst_idx;
   logic [2:0]  tx_idx;
   logic [11:0] wait_slots;
   logic [15:0] lfsr;
   logic        fire;
   logic        fire_unsync;
   logic        chan;
   logic [8:0]  rnd;
   logic        ser_busy;

   assign act       = ctrl[mob_pkg::CTRL_ACT];
   assign ready_all = gnss.fix && gnss.sog_cog && gnss.utc_lock;
   assign rnd       = (lfsr[8:0] > mob_pkg::RAND_SPAN) ? lfsr[8:0] - mob_pkg::RAND_FOLD : lfsr[8:0];
   assign fire      = slot_tick && wait_slots == 12'h000 && !ser_busy
                      && (seq == mob_pkg::ST_RUN || seq == mob_pkg::ST_TRUN);
   assign fire_unsync = seq == mob_pkg::ST_WAIT && ctrl[mob_pkg::CTRL_EARLY] && !early_done && !ser_busy
                      && secs >= 9'(mob_pkg::EARLY_LO_S) && secs < 9'(mob_pkg::EARLY_HI_S);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         lfsr <= 16'hace1;
      else
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         seq        <= mob_pkg::ST_IDLE;
         secs       <= 9'h000;
         started    <= 1'b0;
         abandoned  <= 1'b0;
         early_done <= 1'b0;
         burst_idx  <= 3'h0;
         tx_idx     <= 3'h0;
         wait_slots <= 12'h000;
         chan       <= 1'b0;
         tx_count   <= 8'h00;
      end
      else if (!act)
         seq <= mob_pkg::ST_IDLE;
      else
      begin
         if (sec_tick && secs != 9'h1ff)
            secs <= secs + 9'h001;
         if (fire || fire_unsync)
            tx_count <= tx_count + 8'h01;
         if (slot_tick && wait_slots != 12'h000)
            wait_slots <= wait_slots - 12'h001;
         case (seq)
            mob_pkg::ST_IDLE:
            begin
               secs       <= 9'h000;
               started    <= 1'b0;
               abandoned  <= 1'b0;
               early_done <= 1'b0;
               burst_idx  <= 3'h0;
               tx_idx     <= 3'h0;
               wait_slots <= 12'h000;
               chan       <= 1'b0;
               tx_count   <= 8'h00;
               seq <= ctrl[mob_pkg::CTRL_TEST] ? mob_pkg::ST_TWAIT : mob_pkg::ST_WAIT;
            end
            mob_pkg::ST_WAIT:
            begin
               if (fire_unsync)
                  early_done <= 1'b1;
               if (ready_all || secs >= 9'(mob_pkg::START_MAX_S))
               begin
                  seq     <= mob_pkg::ST_RUN;
                  started <= 1'b1;
               end
            end
            mob_pkg::ST_RUN:
               if (fire)
               begin
                  chan   <= !chan;
                  tx_idx <= tx_idx + 3'h1;
                  if (tx_idx != mob_pkg::LAST_IDX)
                     wait_slots <= mob_pkg::BURST_STEP - 12'h001;
                  else
                  begin
                     burst_idx  <= burst_idx + 3'h1;
                     wait_slots <= (burst_idx == mob_pkg::LAST_IDX)
                                   ? mob_pkg::RAND_BASE + 12'(rnd) : mob_pkg::MINUTE_GAP;
                  end
               end
            mob_pkg::ST_TWAIT:
               if (ready_all)
                  seq <= mob_pkg::ST_TRUN;
               else if (secs >= 9'(mob_pkg::TEST_MAX_S))
               begin
                  seq       <= mob_pkg::ST_DONE;
                  abandoned <= 1'b1;
               end
            mob_pkg::ST_TRUN:
               if (fire)
               begin
                  chan       <= !chan;
                  tx_idx     <= tx_idx + 3'h1;
                  wait_slots <= mob_pkg::BURST_STEP - 12'h001;
                  if (tx_idx == mob_pkg::LAST_IDX)
                     seq <= mob_pkg::ST_DONE;
               end
            mob_pkg::ST_DONE:
               seq <= mob_pkg::ST_DONE;
            default:
               seq <= mob_pkg::ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // message content
   // ****************************************
   logic        test;
   logic        is_txt;
   logic [2:0]  tmo;
   logic [13:0] sub;
   logic [18:0] comm;
   logic [5:0]  ts;
   logic [167:0] payload;

   assign test   = (seq == mob_pkg::ST_TRUN);
   assign is_txt = test ? (tx_idx == 3'h0 || tx_idx == mob_pkg::LAST_IDX)
                        : ((burst_idx == 3'h0 || burst_idx == mob_pkg::M14_A)
                           && (tx_idx == mob_pkg::M14_A || tx_idx == mob_pkg::M14_B));
   assign tmo    = test ? 3'h0 : mob_pkg::LAST_IDX - burst_idx;
   assign ts     = gnss.fix ? utc_sec : mob_pkg::TS_NA;

   always_comb
   begin
      sub = 14'h0000;
      if (!test)
         case (tmo)
            3'h0:       sub = 14'(mob_pkg::MINUTE_GAP);
            3'h1:       sub = {8'h00, utc_sec};
            3'h2, 3'h4, 3'h6: sub = {7'h00, slot_no};
            default:    sub = 14'h0000;
         endcase
   end

   assign comm = {gnss.utc_lock ? 2'h0 : mob_pkg::SYNC_LOST, tmo, sub};

   // defaults stand in the store until a first fix arrives
   always_comb
   begin
      if (is_txt && !fire_unsync)
         payload = {mob_pkg::TYPE_TXT, 2'h0, mmsi, 2'h0,
                    test ? mob_pkg::TXT_TEST : mob_pkg::TXT_ACT, 68'h0};
      else
         payload = {mob_pkg::TYPE_POS, 2'h0, mmsi,
                    test ? mob_pkg::NAV_TEST : mob_pkg::NAV_ACT,
                    mob_pkg::ROT_NA,
                    fire_unsync ? mob_pkg::SOG_NA : sog_q, 1'b0,
                    fire_unsync ? mob_pkg::LON_NA : lon_q,
                    fire_unsync ? mob_pkg::LAT_NA : lat_q,
                    fire_unsync ? mob_pkg::COG_NA : cog_q,
                    mob_pkg::HDG_NA, fire_unsync ? mob_pkg::TS_NA : ts,
                    6'h00, comm};
   end

   // ****************************************
   // serialiser and keying guards
   // ****************************************
   logic [191:0] shreg;
   logic [7:0]  bit_left;
   logic [17:0] phase;
   logic [18:0] key_cyc;
   logic [24:0] stuck_cyc;
   logic        ser_key;
   logic        nrzi;
   logic        tx_chan;

   assign ser_busy = (ser != mob_pkg::SR_IDLE);
   assign ser_key  = ser_busy;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ser      <= mob_pkg::SR_IDLE;
         shreg    <= '0;
         bit_left <= 8'h00;
         phase    <= 18'h00000;
         key_cyc  <= 19'h00000;
         nrzi     <= 1'b0;
         tx_chan  <= 1'b0;
      end
      else
      begin
         key_cyc <= ser_busy ? key_cyc + 19'h00001 : 19'h00000;
         phase   <= phase + 18'h00001;
         case (ser)
            mob_pkg::SR_IDLE:
               if ((fire || fire_unsync) && !shut)
               begin
                  ser      <= mob_pkg::SR_SETTLE;
                  shreg    <= {mob_pkg::TRAIN, payload};
                  bit_left <= 8'(mob_pkg::FRAME_BITS);
                  tx_chan  <= chan;
                  phase    <= 18'h00000;
               end
            mob_pkg::SR_SETTLE:
               if (phase == 18'(SETTLE_CYC - 1))
               begin
                  ser   <= mob_pkg::SR_BITS;
                  phase <= 18'h00000;
               end
            mob_pkg::SR_BITS:
               if (phase == 18'(mob_pkg::BIT_CYC - 1))
               begin
                  phase    <= 18'h00000;
                  nrzi     <= shreg[191] ? nrzi : !nrzi;
                  shreg    <= {shreg[190:0], 1'b0};
                  bit_left <= bit_left - 8'h01;
                  if (bit_left == 8'h01)
                     ser <= mob_pkg::SR_RAMP;
               end
            mob_pkg::SR_RAMP:
               if (phase == 18'(RAMP_CYC - 1))
                  ser <= mob_pkg::SR_IDLE;
            default:
               ser <= mob_pkg::SR_IDLE;
         endcase
         if (ser_busy && (key_cyc == 19'(KEY_MAX_CYC - 1) || shut))
            ser <= mob_pkg::SR_IDLE;
      end
   end

   // watchdog sits on the key itself so it catches a hung sequencer too
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stuck_cyc <= 25'h0000000;
         shut      <= 1'b0;
      end
      else
      begin
         stuck_cyc <= ser_key ? stuck_cyc + 25'h0000001 : 25'h0000000;
         if (stuck_cyc == 25'(STUCK_CYC))
            shut <= 1'b1;
      end
   end

   assign radio.key  = ser_key && !shut;
   assign radio.data = nrzi;
   assign radio.chan = tx_chan;
endmodule : mob_ais_tx_sequencer
`default_nettype wire

// ===== mob_pkg.sv
// shared constants and carrier types for the man-overboard ais transmit sequencer
package mob_pkg;
   // ****************************************
   // timing figures in their own units
   // ****************************************
   localparam int CLK_HZ      = 10_000_000;
   localparam int SEC_S       = 1;
   localparam int SLOT_FRAME_S = 2;
   localparam int SLOTS_FRAME = 75;
   localparam int BIT_RATE    = 9600;
   localparam int SETTLE_US   = 1000;
   localparam int RAMP_US     = 832;
   localparam int KEY_MAX_US  = 26600;
   localparam int STUCK_S     = 2;
   localparam int EARLY_LO_S  = 10;
   localparam int EARLY_HI_S  = 30;
   localparam int START_MAX_S = 60;
   localparam int TEST_MAX_S  = 300;
   localparam int REFRESH_S   = 60;
   localparam int BIT_CYC     = CLK_HZ / BIT_RATE;
   // ****************************************
   // burst plan
   // ****************************************
   localparam logic [2:0]  LAST_IDX   = 3'h7;
   localparam logic [11:0] BURST_STEP = 12'h04b;
   localparam logic [11:0] MINUTE_GAP = 12'h6bd;
   localparam logic [11:0] RAND_BASE  = 12'h5dc;
   localparam logic [8:0]  RAND_SPAN  = 9'h1c2;
   localparam logic [8:0]  RAND_FOLD  = 9'h100;
   localparam logic [2:0]  M14_A      = 3'h4;
   localparam logic [2:0]  M14_B      = 3'h5;
   // ****************************************
   // frame fields
   // ****************************************
   localparam int FRAME_BITS = 192;
   localparam int PAY_BITS   = 168;
   localparam logic [23:0] TRAIN     = 24'h555555;
   localparam logic [5:0]  TYPE_POS  = 6'h01;
   localparam logic [5:0]  TYPE_TXT  = 6'h0e;
   localparam logic [3:0]  NAV_ACT   = 4'he;
   localparam logic [3:0]  NAV_TEST  = 4'hf;
   localparam logic [27:0] LON_NA    = 28'h6791ac0;
   localparam logic [26:0] LAT_NA    = 27'h3412140;
   localparam logic [11:0] COG_NA    = 12'he10;
   localparam logic [9:0]  SOG_NA    = 10'h3ff;
   localparam logic [8:0]  HDG_NA    = 9'h1ff;
   localparam logic [7:0]  ROT_NA    = 8'h80;
   localparam logic [5:0]  TS_NA     = 6'h3f;
   localparam logic [1:0]  SYNC_LOST = 2'h3;
   localparam logic [59:0] TXT_ACT   = {6'h0d, 6'h0f, 6'h02, 6'h20, 6'h01,
                                        6'h03, 6'h14, 6'h09, 6'h16, 6'h05};
   localparam logic [59:0] TXT_TEST  = {6'h0d, 6'h0f, 6'h02, 6'h20, 6'h14,
                                        6'h05, 6'h13, 6'h14, 6'h00, 6'h00};
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LAT    = 8'h08;
   localparam logic [7:0] REG_LON    = 8'h0c;
   localparam logic [7:0] REG_MMSI   = 8'h10;
   localparam int CTRL_ACT   = 0;
   localparam int CTRL_TEST  = 1;
   localparam int CTRL_EARLY = 2;
   localparam int CTRL_LEAP  = 3;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // arbitrary neutral identity, software overwrites it
   localparam logic [29:0] MMSI_RESET = 30'h00000001;

   typedef enum {ST_IDLE, ST_WAIT, ST_RUN, ST_TWAIT, ST_TRUN, ST_DONE} seq_e;
   typedef enum {SR_IDLE, SR_SETTLE, SR_BITS, SR_RAMP} ser_e;

   typedef struct packed {
      logic        fix;
      logic        sog_cog;
      logic        utc_lock;
      logic        pps;
      logic [26:0] lat;
      logic [27:0] lon;
      logic [9:0]  sog;
      logic [11:0] cog;
   } gnss_s;

   typedef struct packed {
      logic key;
      logic data;
      logic chan;
   } radio_s;
endpackage : mob_pkg

// ===== mob_gnss_model.sv
// satellite receiver stand-in: lock, fix and second pulse
`timescale 1ns/1ps
`default_nettype none
module mob_gnss_model #(parameter int SEC_CYC = 2000) (
   input  wire logic      aclk,
   input  wire logic      lock,
   input  wire logic      fix,
   output mob_pkg::gnss_s gnss
);
   int n = 0;
   always_ff @(posedge aclk)
   begin
      n <= (n == SEC_CYC - 1) ? 0 : n + 1;
      gnss.pps <= lock && n == 0;
      gnss.utc_lock <= lock;
      gnss.fix <= fix;
      gnss.sog_cog <= fix;
      // no fix: lat and lon carry junk that moves every cycle
      gnss.lat <= fix ? 27'h0123456 : 27'(n);
      gnss.lon <= fix ? 28'h0abcdef : 28'(n);
      gnss.sog <= 10'h010;
      gnss.cog <= 12'h100;
   end
endmodule : mob_gnss_model
`default_nettype wire

// ===== mob_ais_tx_sequencer_props.sv
// concurrent checks on the transmit sequencer ports
`timescale 1ns/1ps
`default_nettype none
module mob_props #(parameter int STUCK_CYC = 1000) (
   input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire mob_pkg::radio_s radio
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // unbroken keyed cycles
   int held = 0;
   always_ff @(posedge aclk) held <= (aresetn && radio.key) ? held + 1 : 0;
   // both halves are held first, the response follows one edge later
   property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
   a_wr: assert property (p_wr) else $error("no bvalid");
   property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("no rvalid");
   property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rh: assert property (p_rh) else $error("rdata dropped");
   property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bh: assert property (p_bh) else $error("bvalid dropped");
   property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar: assert property (p_ar) else $error("read taken busy");
   property p_cut; held <= STUCK_CYC + 1; endproperty
   a_cut: assert property (p_cut) else $error("stuck key");
   property p_ch; radio.key && $past(radio.key) |-> $stable(radio.chan); endproperty
   a_ch: assert property (p_ch) else $error("chan moved");
   property p_bit; $changed(radio.data) |=> $stable(radio.data) [*8]; endproperty
   a_bit: assert property (p_bit) else $error("short bit");
endmodule : mob_props
bind mob_ais_tx_sequencer mob_props #(.STUCK_CYC(STUCK_CYC)) u_props (.*);
`default_nettype wire

// ===== tb_mob_ais_tx_sequencer.sv
// self-checking bench for the transmit sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; $display("BAD %s %h %h", n, e, s); end end
module tb_mob_ais_tx_sequencer;
   localparam logic [1:0] OK = mob_pkg::RESP_OK;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, lock = 0, fix = 0, seen, pr_seen = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd;
   logic [3:0] ws = 4'hf;
   logic awr, wrd, bv, arr, rv, leap, pr;
   logic [1:0] br, rr;
   mob_pkg::gnss_s g;
   mob_pkg::radio_s radio;
   int n_mismatch = 0, tests_run = 0, cyc = 0;
   always #50 aclk = ~aclk;
   mob_gnss_model GM (.aclk(aclk), .lock(lock), .fix(fix), .gnss(g));
   // local seconds are shortened so the one-minute and lock-timeout figures fall inside the run
   mob_ais_tx_sequencer #(.SEC_CYC(200), .SLOT_CYC(4000), .SETTLE_CYC(10), .RAMP_CYC(8), .STUCK_CYC(3000)) DUT (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .gnss(g), .radio(radio), .pos_refresh(pr),
      .leap_aid(leap));
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = OK, input logic [3:0] s = 4'hf);
      @(posedge aclk);
      {awa, wd, ws, awv, wv, bry} <= {a, d, s, 3'h7};
      do
      begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end
      while (!bv);
      bry <= 0;
      `CHK("bresp", e, br)
   endtask : wr
   task rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1, input logic [1:0] e = OK);
      @(posedge aclk);
      {ara, arv, rry} <= {a, 2'h3};
      do
      begin
         @(posedge aclk);
         if (arr) arv <= 0;
      end
      while (!rv);
      rry <= 0;
      `CHK("rdata", x, rd & m)
      `CHK("rresp", e, rr)
   endtask : rdc
   task wait_key(input logic v, input int n);
      repeat (n) if (radio.key !== v) @(posedge aclk);
      `CHK("key", v, radio.key)
   endtask : wait_key
   task t_regs;
      rdc(mob_pkg::REG_CTRL, 0);
      rdc(mob_pkg::REG_MMSI, 32'(mob_pkg::MMSI_RESET));
      rdc(mob_pkg::REG_LAT, 32'(mob_pkg::LAT_NA));
      rdc(mob_pkg::REG_LON, 32'(mob_pkg::LON_NA));
      rdc(8'h40, 0, '1, mob_pkg::RESP_ERR);
      wr(8'h40, 0, mob_pkg::RESP_ERR);
      wr(mob_pkg::REG_MMSI, 32'h3fffffff, OK, 4'h3);
      rdc(mob_pkg::REG_MMSI, 32'h0000ffff);
      wr(mob_pkg::REG_CTRL, 32'h8);
      `CHK("leap", 1'b1, leap)
      wr(mob_pkg::REG_CTRL, 0, OK, 4'he);
      `CHK("leap kept", 1'b1, leap)
   endtask : t_regs
   task t_test;
      fix <= 1;
      wr(mob_pkg::REG_CTRL, 32'h3);
      seen = 0;
      repeat (3000) @(posedge aclk) seen |= radio.key;
      `CHK("test hold", 1'b0, seen)
      rdc(mob_pkg::REG_STATUS, 3, 32'hf);
      repeat (58000) @(posedge aclk)
      begin
         seen |= radio.key;
         pr_seen |= pr;
      end
      `CHK("test quiet", 1'b0, seen)
      `CHK("refresh", 1'b1, pr_seen)
      rdc(mob_pkg::REG_STATUS, 32'h25, 32'h3f);
      wr(mob_pkg::REG_CTRL, 0);
   endtask : t_test
   task t_act;
      lock <= 1;
      wr(mob_pkg::REG_CTRL, 32'h1);
      wait_key(1, 40000);
      `CHK("chan", 1'b0, radio.chan)
      // key outlasts the short stuck limit, so the guard must cut it
      wait_key(0, 3100);
      rdc(mob_pkg::REG_STATUS, 32'h10, 32'h10);
   endtask : t_act
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         n_mismatch++;
         report_and_stop;
      end
   end
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      t_regs;
      t_test;
      t_act;
      report_and_stop;
   end
endmodule : tb_mob_ais_tx_sequencer
`default_nettype wire
